// ==== abn_encoder_model.sv ====
// Behavioural incremental ABN encoder for one axis
`timescale 1ns/100ps

module abn_encoder_model (
    input  wire logic core_clk,
    output logic      a,
    output logic      b,
    output logic      n
);
    logic [1:0] ph;

    initial begin
        ph = 2'h0;
        a = 1'b0;
        b = 1'b0;
        n = 1'b0;
    end

    task automatic step(input bit up, input int cnt);
        repeat (cnt) begin
            ph = up ? ph + 2'h1 : ph - 2'h1;
            a <= ph[1] ^ ph[0];
            b <= ph[1];
            repeat (8) @(posedge core_clk);
        end
    endtask

    task automatic index;
        n <= 1'b1;
        repeat (8) @(posedge core_clk);
        n <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask

    task automatic spike;
        a <= ~a;
        repeat (2) @(posedge core_clk);
        a <= ~a;
        repeat (16) @(posedge core_clk);
    endtask
endmodule

// ==== input_filter.v ====
// Three-stage synchroniser and spike filter for one encoder pin
`timescale 1ns/100ps

module input_filter (
    input  wire core_clk,
    input  wire rst_b,
    input  wire pin,
    output reg  level
);

`include "qei_defs.vh"

reg       sync_1;
reg       sync_2;
reg       sync_3;
reg [1:0] stable_cnt;

// ---------------------------------------------------------------
// Synchroniser and stability counter
// ---------------------------------------------------------------
always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        sync_1     <= 1'b0;
        sync_2     <= 1'b0;
        sync_3     <= 1'b0;
        level      <= 1'b0;
        stable_cnt <= 2'b00;
    end else begin
        sync_1 <= pin;
        sync_2 <= sync_1;
        sync_3 <= sync_2;
        // R18: spike rejection
        if (sync_2 == sync_3 && sync_3 != level) begin
            // R17: rate limit
            if (stable_cnt == `FILT_LAST) begin
                level      <= sync_3;
                stable_cnt <= 2'b00;
            end else begin
                stable_cnt <= stable_cnt + 2'd1;
            end
        end else begin
            stable_cnt <= 2'b00;
        end
    end
end

endmodule

// ==== qei_checker.sv ====
// Bus and counting checks bound to the encoder interface
`timescale 1ns/100ps

module qei_checker (
    input wire logic        core_clk,
    input wire logic        rst_b,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [1:0]  enc_a,
    input wire logic [1:0]  enc_b,
    input wire logic [1:0]  enc_n,
    input wire logic [31:0] encoder_position_value0
);
    logic [5:0] pins_q;
    logic [3:0] quiet;

    // ------------------------------
    // Cycles since a pin last moved
    // ------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pins_q <= 6'h00;
            quiet  <= 4'h0;
        end else begin
            pins_q <= {enc_a, enc_b, enc_n};
            if (pins_q != {enc_a, enc_b, enc_n})
                quiet <= 4'h0;
            else if (quiet != 4'hf)
                quiet <= quiet + 4'h1;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence spike_a;
        quiet == 4'hf && $changed(enc_a[0])
        ##1 !$changed(enc_a[0]) && $stable(enc_b) && $stable(enc_n)
        ##1 $changed(enc_a[0]) && $stable(enc_b) && $stable(enc_n);
    endsequence

    AST_POS_QUIET: assert property (
        quiet == 4'hf && !$rose(s_axi_bvalid)
        |-> $stable(encoder_position_value0)) else $error("pos moved");
    AST_SPIKE: assert property (
        spike_a |-> ##1 ($stable(encoder_position_value0)
        || $rose(s_axi_bvalid))[*6]) else $error("spike counted");
    AST_B_LAT: assert property (
        wr_taken |-> ##[2:3] $rose(s_axi_bvalid)) else $error("no bvalid");
    AST_R_LAT: assert property (
        s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("no rvalid");
    AST_B_HOLD: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("bresp dropped");
    AST_R_HOLD: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("rdata dropped");
    AST_B_DONE: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready
        && s_axi_wready) else $error("write not closed");
    AST_AW_BLOCK: assert property (
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("awready stayed high");
    AST_AR_BLOCK: assert property (
        s_axi_rvalid |-> !s_axi_arready) else $error("arready high");
endmodule

bind quadrature_encoder_interface qei_checker i_qei_checker (
    .core_clk(core_clk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .enc_a(enc_a), .enc_b(enc_b),
    .enc_n(enc_n), .encoder_position_value0(encoder_position_value0)
);

// ==== qei_defs.vh ====
// Register map, field positions and timing constants of the encoder block
`ifndef QEI_DEFS_VH
`define QEI_DEFS_VH

// ---------------------------------------------------------------
// Bus and address map
// ---------------------------------------------------------------
`define ADDR_W          8
`define GLOBAL_CONFIG   8'h00
`define AXIS_BASE0      3'd1
`define AXIS_BASE1      3'd2
`define OFS_MODE        5'h00
`define OFS_CONST       5'h04
`define OFS_POS         5'h08
`define OFS_STATUS      5'h0c
`define OFS_CAPTURE     5'h10
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

// ---------------------------------------------------------------
// Fields of encoder_mode_config
// ---------------------------------------------------------------
`define MODE_W          8
`define MODE_POL_A      0
`define MODE_POL_B      1
`define MODE_POL_N      2
`define MODE_IGNORE_AB  3
`define MODE_CLR_CONT   4
`define MODE_CLR_ONCE   5
`define MODE_CLR_ON_N   6
`define MODE_DECIMAL    7

// ---------------------------------------------------------------
// Fields of encoder_event_status, reset values
// ---------------------------------------------------------------
`define STAT_CLEARED    0
`define STAT_INDEX      1
`define MODE_RESET      8'h04
`define CONST_RESET     32'h0001_0000
`define GLOBAL_CONFIG_RESET     2'b00

// ---------------------------------------------------------------
// Arithmetic and filter timing
// ---------------------------------------------------------------
`define DEC_WRAP        17'd10000
`define FILT_LAST       2'd2

`endif

// ==== quadrature_encoder_interface.v ====
// Dual-axis ABN quadrature encoder interface with AXI4-Lite registers
//
// Behaviour
// R01: two independent axes, each fully separate
// R02: global_config selects pins as encoder inputs
// R03: counting works with A and B alone
// R04: accepted index clears or captures position
// R05: continuous mode acts on every index
// R06: single-shot acts once then disarms
// R07: index accepted only at configured A/B levels
// R08: clear needs clear-on-index plus once/cont
// R09: each A/B change adds or subtracts constant
// R10: binary mode constant is signed 16.16
// R11: decimal mode fraction 0..9999, carries at 10000
// R12: negative constant reverses counting direction
// R13: software encodes negative decimal constants
// R14: position counter readable at any time
// R15: status records index-triggered clear
// R16: capture register snapshots position on index
// R17: filtering limits rate to 2/3 clock
// R18: inputs reject spikes under three clocks
// R19: active-low and active-high signals supported
// R20: phase order gives direction, double steps ignored
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "qei_defs.vh"

module quadrature_encoder_interface (
    input  wire                 core_clk,
    input  wire                 rst_b,
    input  wire [`ADDR_W-1:0]   s_axi_awaddr,
    input  wire                 s_axi_awvalid,
    output reg                  s_axi_awready,
    input  wire [31:0]          s_axi_wdata,
    input  wire [3:0]           s_axi_wstrb,
    input  wire                 s_axi_wvalid,
    output reg                  s_axi_wready,
    output reg  [1:0]           s_axi_bresp,
    output reg                  s_axi_bvalid,
    input  wire                 s_axi_bready,
    input  wire [`ADDR_W-1:0]   s_axi_araddr,
    input  wire                 s_axi_arvalid,
    output reg                  s_axi_arready,
    output reg  [31:0]          s_axi_rdata,
    output reg  [1:0]           s_axi_rresp,
    output reg                  s_axi_rvalid,
    input  wire                 s_axi_rready,
    input  wire [1:0]           enc_a,
    input  wire [1:0]           enc_b,
    input  wire [1:0]           enc_n,
    output wire [31:0]          encoder_position_value0,
    output wire [31:0]          encoder_position_value1
);

// ---------------------------------------------------------------
// Helpers
// ---------------------------------------------------------------
function [31:0] merge_bytes;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer      k;
    begin
        merge_bytes = old;
        for (k = 0; k < 4; k = k + 1) begin
            if (strb[k])
                merge_bytes[k*8 +: 8] = data[k*8 +: 8];
        end
    end
endfunction

function [31:0] step_position;
    input [31:0] pos;
    input [31:0] scale;
    input        decimal;
    input        up;
    reg   [16:0] frac;
    reg   [15:0] carry;
    begin
        frac  = 17'd0;
        carry = 16'd0;
        if (!decimal) begin
            step_position = up ? pos + scale : pos - scale;
        end else if (up) begin
            frac = {1'b0, pos[15:0]} + {1'b0, scale[15:0]};
            if (frac >= `DEC_WRAP) begin
                frac  = frac - `DEC_WRAP;
                carry = 16'd1;
            end
            step_position = {pos[31:16] + scale[31:16] + carry,
                             frac[15:0]};
        end else begin
            frac = {1'b0, pos[15:0]} - {1'b0, scale[15:0]};
            if (frac[16]) begin
                frac  = frac + `DEC_WRAP;
                carry = 16'd1;
            end
            step_position = {pos[31:16] - scale[31:16] - carry,
                             frac[15:0]};
        end
    end
endfunction

// Axis number for an address, 2 when not an axis window
function [1:0] axis_of;
    input [`ADDR_W-1:0] addr;
    begin
        if (addr[7:5] == `AXIS_BASE0)
            axis_of = 2'd0;
        else if (addr[7:5] == `AXIS_BASE1)
            axis_of = 2'd1;
        else
            axis_of = 2'd2;
    end
endfunction

function addr_mapped;
    input [`ADDR_W-1:0] addr;
    begin
        addr_mapped = (addr == `GLOBAL_CONFIG) ||
                      (axis_of(addr) != 2'd2 && addr[1:0] == 2'b00 &&
                       addr[4:0] <= `OFS_CAPTURE);
    end
endfunction

// ---------------------------------------------------------------
// Write channel capture
// ---------------------------------------------------------------
reg                 aw_held;
reg                 w_held;
reg [`ADDR_W-1:0]   wr_addr;
reg [31:0]          wr_data;
reg [3:0]           wr_strb;
reg [1:0]           global_config;
wire                wr_go;

assign wr_go   = aw_held & w_held & ~s_axi_bvalid;

always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        aw_held       <= 1'b0;
        w_held        <= 1'b0;
        wr_addr       <= {`ADDR_W{1'b0}};
        wr_data       <= 32'h0000_0000;
        wr_strb       <= 4'h0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= `RESP_OKAY;
        global_config <= `GLOBAL_CONFIG_RESET;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held       <= 1'b1;
            wr_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held       <= 1'b1;
            wr_data      <= s_axi_wdata;
            wr_strb      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        if (wr_go) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_mapped(wr_addr) ? `RESP_OKAY
                                                 : `RESP_SLVERR;
            // R02: pin function select
            if (wr_addr == `GLOBAL_CONFIG && wr_strb[0])
                global_config <= wr_data[1:0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
        end
    end
end

// ---------------------------------------------------------------
// Per-axis encoder logic
// ---------------------------------------------------------------
wire [2*`MODE_W-1:0] mode_all;
wire [63:0]          const_all;
wire [63:0]          pos_all;
wire [3:0]           stat_all;
wire [63:0]          cap_all;

assign encoder_position_value0 = pos_all[31:0];
assign encoder_position_value1 = pos_all[63:32];

genvar ax;
generate
    // R01: one copy per axis
    for (ax = 0; ax < 2; ax = ax + 1) begin : axis
        reg  [`MODE_W-1:0] encoder_mode_config;
        reg  [31:0]        encoder_scale_constant;
        reg  [31:0]        encoder_position_counter;
        reg  [1:0]         encoder_event_status;
        reg  [31:0]        encoder_index_capture;
        reg                prev_a;
        reg                prev_b;
        reg                prev_n;
        wire               fa;
        wire               fb;
        wire               fn;
        wire               sel;
        wire               a_chg;
        wire               b_chg;
        wire               step;
        wire               up;
        wire               n_active;
        wire               ab_match;
        wire               index_ok;
        wire [31:0]        stepped;

        input_filter filt_a (
            .core_clk (core_clk),
            .rst_b    (rst_b),
            .pin      (enc_a[ax]),
            .level    (fa)
        );
        input_filter filt_b (
            .core_clk (core_clk),
            .rst_b    (rst_b),
            .pin      (enc_b[ax]),
            .level    (fb)
        );
        input_filter filt_n (
            .core_clk (core_clk),
            .rst_b    (rst_b),
            .pin      (enc_n[ax]),
            .level    (fn)
        );

        assign sel   = wr_go && axis_of(wr_addr) == ax;
        assign a_chg = fa ^ prev_a;
        assign b_chg = fb ^ prev_b;
        // R20: direction from phase order
        assign step  = global_config[ax] & (a_chg ^ b_chg);
        assign up    = a_chg ? (fa != fb) : (fa == fb);
        // R09: add or subtract per change
        assign stepped = step_position(encoder_position_counter,
                             encoder_scale_constant,
                             encoder_mode_config[`MODE_DECIMAL], up);
        // R19: selectable index level
        assign n_active = ~(fn ^ encoder_mode_config[`MODE_POL_N]);
        // R07: A/B qualification
        assign ab_match = encoder_mode_config[`MODE_IGNORE_AB] ||
                          (fa == encoder_mode_config[`MODE_POL_A] &&
                           fb == encoder_mode_config[`MODE_POL_B]);
        // R03: index optional
        assign index_ok = global_config[ax] & n_active & ~prev_n &
                          ab_match;

        always @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
                encoder_mode_config      <= `MODE_RESET;
                encoder_scale_constant   <= `CONST_RESET;
                encoder_position_counter <= 32'h0000_0000;
                encoder_event_status     <= 2'b00;
                encoder_index_capture    <= 32'h0000_0000;
                prev_a                   <= 1'b0;
                prev_b                   <= 1'b0;
                prev_n                   <= 1'b1;
            end else begin
                prev_a <= fa;
                prev_b <= fb;
                prev_n <= n_active;
                // R10: binary 16.16 step
                // R11: decimal carry at 10000
                // R12: sign of constant sets direction
                if (step)
                    encoder_position_counter <= stepped;
                // R14: software may preset position
                if (sel && wr_addr[4:0] == `OFS_POS)
                    encoder_position_counter <= merge_bytes(
                        encoder_position_counter, wr_data, wr_strb);
                if (sel && wr_addr[4:0] == `OFS_CONST)
                    encoder_scale_constant <= merge_bytes(
                        encoder_scale_constant, wr_data, wr_strb);
                if (sel && wr_addr[4:0] == `OFS_MODE && wr_strb[0])
                    encoder_mode_config <= wr_data[`MODE_W-1:0];
                // Write one clears; new event below wins
                if (sel && wr_addr[4:0] == `OFS_STATUS && wr_strb[0])
                    encoder_event_status <= encoder_event_status &
                                            ~wr_data[1:0];
                // R04: index clear or capture
                if (index_ok && (encoder_mode_config[`MODE_CLR_CONT] |
                                 encoder_mode_config[`MODE_CLR_ONCE])) begin
                    encoder_event_status[`STAT_INDEX] <= 1'b1;
                    // R16: snapshot on index
                    encoder_index_capture <= encoder_position_counter;
                    // R08: clear needs clear-on-index
                    if (encoder_mode_config[`MODE_CLR_ON_N]) begin
                        encoder_position_counter <= 32'h0000_0000;
                        // R15: clear event recorded
                        encoder_event_status[`STAT_CLEARED] <= 1'b1;
                    end
                    // R06: single-shot disarms
                    // R05: continuous stays armed
                    if (!(sel && wr_addr[4:0] == `OFS_MODE &&
                          wr_strb[0]))
                        encoder_mode_config[`MODE_CLR_ONCE] <= 1'b0;
                end
            end
        end

        assign mode_all[ax*`MODE_W +: `MODE_W] = encoder_mode_config;
        assign const_all[ax*32 +: 32]          = encoder_scale_constant;
        assign pos_all[ax*32 +: 32]            = encoder_position_counter;
        assign stat_all[ax*2 +: 2]             = encoder_event_status;
        assign cap_all[ax*32 +: 32]            = encoder_index_capture;
    end
endgenerate

// ---------------------------------------------------------------
// Read channel
// ---------------------------------------------------------------
reg  [31:0] rd_value;
wire [1:0]  rd_axis;

assign rd_axis = axis_of(s_axi_araddr);

always @* begin
    rd_value = 32'h0000_0000;
    if (s_axi_araddr == `GLOBAL_CONFIG) begin
        rd_value = {30'h0, global_config};
    end else if (rd_axis != 2'd2) begin
        case (s_axi_araddr[4:0])
            `OFS_MODE:
                rd_value = {24'h00_0000,
                            mode_all[rd_axis[0]*`MODE_W +: `MODE_W]};
            `OFS_CONST:   rd_value = const_all[rd_axis[0]*32 +: 32];
            `OFS_POS:     rd_value = pos_all[rd_axis[0]*32 +: 32];
            `OFS_STATUS:  rd_value = {30'h0,
                                      stat_all[rd_axis[0]*2 +: 2]};
            `OFS_CAPTURE: rd_value = cap_all[rd_axis[0]*32 +: 32];
            default:      rd_value = 32'h0000_0000;
        endcase
    end
end

always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h0000_0000;
        s_axi_rresp   <= `RESP_OKAY;
    end else begin
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_value;
            s_axi_rresp   <= addr_mapped(s_axi_araddr) ? `RESP_OKAY
                                                       : `RESP_SLVERR;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
end

endmodule

// ==== tb_top.sv ====
// Self-checking bench for the dual-axis encoder interface
`timescale 1ns/100ps
`include "qei_defs.vh"

module tb_top;
    localparam logic [7:0] MODE0 = {`AXIS_BASE0, `OFS_MODE};
    localparam logic [7:0] CNST0 = {`AXIS_BASE0, `OFS_CONST};
    localparam logic [7:0] POS0  = {`AXIS_BASE0, `OFS_POS};
    localparam logic [7:0] STAT0 = {`AXIS_BASE0, `OFS_STATUS};
    localparam logic [7:0] CAP0  = {`AXIS_BASE0, `OFS_CAPTURE};
    localparam logic [1:0] OK    = `RESP_OKAY;

    logic        core_clk, rst_b, awvalid, awready, wvalid, wready;
    logic        bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, pos0, pos1, rd_val;
    logic [1:0]  bresp, rresp, rd_resp;
    logic [3:0]  wstrb;
    wire  [1:0]  enc_a, enc_b, enc_n;
    int          n_mismatch, n_tests, cyc;

    quadrature_encoder_interface i_quadrature_encoder_interface (
        .core_clk(core_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n),
        .encoder_position_value0(pos0), .encoder_position_value1(pos1)
    );
    abn_encoder_model i_abn_encoder_model_0 (
        .core_clk(core_clk), .a(enc_a[0]), .b(enc_b[0]), .n(enc_n[0])
    );
    abn_encoder_model i_abn_encoder_model_1 (
        .core_clk(core_clk), .a(enc_a[1]), .b(enc_b[1]), .n(enc_n[1])
    );

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out;
        end
    end

    // ------------------------------
    // Shared helpers
    // ------------------------------
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] d,
                      input logic [1:0] er);
        awaddr <= ad;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b1;
        @(posedge core_clk);
        check({30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] ad);
        araddr <= ad;
        arvalid <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b1;
        @(posedge core_clk);
        rd_val = rdata;
        rd_resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic chk(input logic [7:0] ad, input logic [31:0] exp);
        rd(ad);
        check(rd_val, exp);
    endtask

    task automatic settle;
        repeat (16) @(posedge core_clk);
    endtask

    task automatic st0(input bit up, input int cnt);
        i_abn_encoder_model_0.step(up, cnt);
        settle;
    endtask

    task automatic idx0;
        i_abn_encoder_model_0.index;
        settle;
    endtask

    // ------------------------------
    // Scenarios
    // ------------------------------
    task automatic t_count;
        chk(MODE0, 32'h4);
        chk(8'hfc, 32'h0);
        check({30'h0, rd_resp}, {30'h0, `RESP_SLVERR});
        wr(8'hfc, 32'h1, `RESP_SLVERR);
        st0(1'b1, 2);
        check(pos0, 32'h0);
        wr(`GLOBAL_CONFIG, 32'h3, OK);
        st0(1'b1, 4);
        st0(1'b0, 1);
        i_abn_encoder_model_1.step(1'b0, 1);
        settle;
        chk(POS0, 32'h0003_0000);
        check(pos1, 32'hffff_0000);
        i_abn_encoder_model_0.spike;
        check(pos0, 32'h0003_0000);
        $display("test count done");
    endtask

    task automatic t_scale;
        wr(CNST0, 32'hffff_8000, OK);
        wr(POS0, 32'h0, OK);
        st0(1'b1, 2);
        check(pos0, 32'hffff_0000);
        wr(MODE0, 32'h84, OK);
        wr(CNST0, 32'h0000_1770, OK);
        wr(POS0, 32'h0, OK);
        st0(1'b1, 3);
        check(pos0, 32'h0001_1f40);
        wr(CNST0, 32'hffff_0fa0, OK);
        st0(1'b1, 1);
        check(pos0, 32'h0001_07d0);
        $display("test scale done");
    endtask

    task automatic t_index;
        wr(MODE0, 32'h66, OK);
        wr(CNST0, 32'h0001_0000, OK);
        wr(POS0, 32'h0005_0000, OK);
        idx0;
        check(pos0, 32'h0);
        chk(CAP0, 32'h0005_0000);
        chk(STAT0, 32'h3);
        chk(MODE0, 32'h46);
        wr(POS0, 32'h0002_0000, OK);
        idx0;
        check(pos0, 32'h0002_0000);
        wr(STAT0, 32'h3, OK);
        wr(MODE0, 32'h17, OK);
        idx0;
        chk(STAT0, 32'h0);
        wr(MODE0, 32'h16, OK);
        idx0;
        st0(1'b1, 4);
        idx0;
        check(pos0, 32'h0006_0000);
        chk(CAP0, 32'h0006_0000);
        chk(STAT0, 32'h2);
        wr(MODE0, 32'h08, OK);
        wr(MODE0, 32'h58, OK);
        idx0;
        check(pos0, 32'h0);
        chk(STAT0, 32'h3);
        $display("test index done");
    endtask

    initial begin
        {rst_b, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hf;
        {n_mismatch, n_tests, cyc} = 96'h0;
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        t_count;
        t_scale;
        t_index;
        close_out;
    end
endmodule
